// File: rtl/hrp_consts.svh
// Constants for the host register port controller.
// Assumes a 100 MHz clock; all counts are in clock cycles.
`ifndef HRP_CONSTS_SVH
`define HRP_CONSTS_SVH

`define HRP_CLK_PERIOD_NS 10
// Phase times chosen for a slow asynchronous port
`define HRP_SETUP_NS 20
`define HRP_STROBE_NS 60
`define HRP_HOLD_NS 20
`define HRP_RESET_NS 1000
`define HRP_SETUP_CYC ((`HRP_SETUP_NS + `HRP_CLK_PERIOD_NS - 1) / `HRP_CLK_PERIOD_NS)
`define HRP_STROBE_CYC ((`HRP_STROBE_NS + `HRP_CLK_PERIOD_NS - 1) / `HRP_CLK_PERIOD_NS)
`define HRP_HOLD_CYC ((`HRP_HOLD_NS + `HRP_CLK_PERIOD_NS - 1) / `HRP_CLK_PERIOD_NS)
`define HRP_RESET_CYC ((`HRP_RESET_NS + `HRP_CLK_PERIOD_NS - 1) / `HRP_CLK_PERIOD_NS)
`define HRP_CNT_W 8

`endif

// File: rtl/hrp_host.sv
// Host-side controller for the device's asynchronous 8-bit register port.
// Assumes bus_protocol_select is strapped and only changes under reset;
// the device's data pins and interrupt pin arrive asynchronously.
// Phase lengths are fixed counts; a slower device needs the counts raised.
`timescale 1ns/100ps
`include "hrp_consts.svh"
module hrp_host (
    input wire logic clock,
    input wire logic rst,
    // User request side
    input wire logic req_valid,
    output logic req_ready,
    input wire hrp_pkg::hrp_req_s req,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    input wire logic device_reset_req,
    output logic irq_pending,
    // Strap that also goes straight to the device; the host only reads it
    input wire logic bus_protocol_select,
    // Device pins
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [12:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic device_reset_n,
    input wire logic interrupt_out_n
);
    localparam logic [`HRP_CNT_W-1:0] SETUP_CYC = `HRP_CNT_W'(`HRP_SETUP_CYC);
    localparam logic [`HRP_CNT_W-1:0] STROBE_CYC = `HRP_CNT_W'(`HRP_STROBE_CYC);
    localparam logic [`HRP_CNT_W-1:0] HOLD_CYC = `HRP_CNT_W'(`HRP_HOLD_CYC);
    localparam logic [`HRP_CNT_W-1:0] RESET_CYC = `HRP_CNT_W'(`HRP_RESET_CYC);
    // Pin levels between accesses: deselected, strobes high, bus released
    localparam hrp_pkg::hrp_pins_s PINS_IDLE = '{chip_select_n: 1'b1, read_strobe_n: 1'b1,
        write_strobe_n: 1'b1, addr: '0, data_out: '0, data_oe: 1'b0};

    hrp_pkg::hrp_state_e state_ff, nxt_state;
    logic [`HRP_CNT_W-1:0] cnt_ff, nxt_cnt;
    hrp_pkg::hrp_req_s cur_ff;
    hrp_pkg::hrp_pins_s pins_ff, nxt_pins;
    logic rsp_valid_ff;
    logic [7:0] rdata_ff;
    logic mode_ds_ff;
    logic [9:0] sync_out;
    logic strap_sync;
    logic take_req;
    logic dev_reset_n_ff;

    // Data, interrupt and strap cross from asynchronous pins; the strap is
    // quasi-static but still passes two flops so no logic sees it mid-change
    hrp_sync2 #(.WIDTH(10)) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in({bus_protocol_select, ~interrupt_out_n, data_in}),
        .sync_out(sync_out)
    );

    assign strap_sync = sync_out[9];

    // Strobe levels for the active phase of an access in either protocol
    function automatic logic [1:0] strobe_levels(input logic ds_mode, input logic wr);
        if (ds_mode) begin
            // Data strobe low; direction high reads, low writes
            strobe_levels = {1'b0, ~wr};
        end else begin
            // Separate strobes, only one ever low
            strobe_levels = {wr, ~wr};
        end
    endfunction : strobe_levels

    // Idle levels: strobes high; in data strobe mode the direction is high for a read, low for a write
    function automatic logic [1:0] idle_levels(input logic ds_mode, input logic wr);
        idle_levels = ds_mode ? {1'b1, ~wr} : 2'b11;
    endfunction : idle_levels

    // Last cycle of a timed phase; every phase counts down to one
    function automatic logic phase_done(input logic [`HRP_CNT_W-1:0] cnt);
        phase_done = (cnt == `HRP_CNT_W'(1));
    endfunction : phase_done

    // A request is taken only in idle and never while a device reset is asked for
    assign take_req = (state_ff == hrp_pkg::HRP_IDLE) && req_valid && !device_reset_req;

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_ds_ff <= 1'b0;
        end else if (state_ff == hrp_pkg::HRP_RESET) begin
            // Strap caught while the device is held in reset
            mode_ds_ff <= strap_sync;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_pins = pins_ff;
        unique case (state_ff)
            hrp_pkg::HRP_IDLE: begin
                if (device_reset_req) begin
                    nxt_state = hrp_pkg::HRP_RESET;
                    nxt_cnt = RESET_CYC;
                end else if (req_valid) begin
                    // Address and select set up before the strobe
                    nxt_state = hrp_pkg::HRP_SETUP;
                    nxt_cnt = SETUP_CYC;
                    nxt_pins.chip_select_n = 1'b0;
                    nxt_pins.addr = req.addr;
                    nxt_pins.data_out = req.wdata;
                    nxt_pins.data_oe = req.write;
                    {nxt_pins.read_strobe_n, nxt_pins.write_strobe_n} =
                        idle_levels(mode_ds_ff, req.write);
                end
            end
            hrp_pkg::HRP_SETUP: begin
                nxt_cnt = cnt_ff - `HRP_CNT_W'(1);
                if (phase_done(cnt_ff)) begin
                    nxt_state = hrp_pkg::HRP_STROBE;
                    nxt_cnt = STROBE_CYC;
                    {nxt_pins.read_strobe_n, nxt_pins.write_strobe_n} =
                        strobe_levels(mode_ds_ff, cur_ff.write);
                end
            end
            hrp_pkg::HRP_STROBE: begin
                nxt_cnt = cnt_ff - `HRP_CNT_W'(1);
                if (phase_done(cnt_ff)) begin
                    // Strobe rises while select is still low, so the write lands
                    nxt_state = hrp_pkg::HRP_HOLD;
                    nxt_cnt = HOLD_CYC;
                    {nxt_pins.read_strobe_n, nxt_pins.write_strobe_n} =
                        idle_levels(mode_ds_ff, cur_ff.write);
                end
            end
            hrp_pkg::HRP_HOLD: begin
                nxt_cnt = cnt_ff - `HRP_CNT_W'(1);
                if (phase_done(cnt_ff)) begin
                    nxt_state = hrp_pkg::HRP_IDLE;
                    nxt_pins.chip_select_n = 1'b1;
                    nxt_pins.data_oe = 1'b0;
                    {nxt_pins.read_strobe_n, nxt_pins.write_strobe_n} =
                        idle_levels(mode_ds_ff, 1'b0);
                end
            end
            hrp_pkg::HRP_RESET: begin
                nxt_cnt = cnt_ff - `HRP_CNT_W'(1);
                if (phase_done(cnt_ff)) begin
                    nxt_state = hrp_pkg::HRP_IDLE;
                    {nxt_pins.read_strobe_n, nxt_pins.write_strobe_n} =
                        idle_levels(strap_sync, 1'b0);
                end
            end
            // Codes outside the enum send the port back to a safe idle
            default: begin
                nxt_state = hrp_pkg::HRP_IDLE;
                nxt_cnt = '0;
                nxt_pins = PINS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= hrp_pkg::HRP_IDLE;
            cnt_ff <= '0;
            pins_ff <= PINS_IDLE;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            pins_ff <= nxt_pins;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cur_ff <= '0;
        end else if (take_req) begin
            cur_ff <= req;
        end
    end

    // Read data is sampled at the end of the strobe; the two-flop delay
    // is covered because the strobe lasts well over two cycles
    always_ff @(posedge clock) begin
        if (rst) begin
            rsp_valid_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            rsp_valid_ff <= 1'b0;
            if (state_ff == hrp_pkg::HRP_STROBE && phase_done(cnt_ff) && !cur_ff.write) begin
                rdata_ff <= sync_out[7:0];
            end
            if (state_ff == hrp_pkg::HRP_HOLD && phase_done(cnt_ff)) begin
                rsp_valid_ff <= 1'b1;
            end
        end
    end

    // Reset pin comes from a flop so it cannot glitch while the state decodes;
    // it follows the state register exactly, one pulse of RESET_CYC cycles
    always_ff @(posedge clock) begin
        if (rst) begin
            dev_reset_n_ff <= 1'b1;
        end else begin
            dev_reset_n_ff <= (nxt_state != hrp_pkg::HRP_RESET);
        end
    end

    assign req_ready = (state_ff == hrp_pkg::HRP_IDLE) && !device_reset_req;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_rdata = rdata_ff;
    // Masking and clearing live in device registers; the pin only reports
    assign irq_pending = sync_out[8];
    assign chip_select_n = pins_ff.chip_select_n;
    assign read_strobe_n = pins_ff.read_strobe_n;
    assign write_strobe_n = pins_ff.write_strobe_n;
    assign addr = pins_ff.addr;
    assign data_out = pins_ff.data_out;
    assign data_oe = pins_ff.data_oe;
    assign device_reset_n = dev_reset_n_ff;
endmodule : hrp_host

// File: rtl/hrp_pkg.sv
// Types for the host register port controller.
// Used by the controller and its testbench.
package hrp_pkg;
    typedef logic [12:0] hrp_addr_t;
    typedef logic [7:0] hrp_data_t;

    typedef struct packed {
        logic write;
        hrp_addr_t addr;
        hrp_data_t wdata;
    } hrp_req_s;

    typedef struct packed {
        logic chip_select_n;
        logic read_strobe_n;
        logic write_strobe_n;
        hrp_addr_t addr;
        hrp_data_t data_out;
        logic data_oe;
    } hrp_pins_s;

    typedef enum logic [2:0] {
        HRP_IDLE,
        HRP_SETUP,
        HRP_STROBE,
        HRP_HOLD,
        HRP_RESET
    } hrp_state_e;
endpackage : hrp_pkg

// File: rtl/hrp_sync2.sv
// Two-flop synchroniser for a few asynchronous input pins.
// Assumes the pins are quasi-static or sampled for levels only.
`timescale 1ns/100ps
module hrp_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule : hrp_sync2

// File: sim/host_register_port_bench.sv
// Self-checking bench for hrp_host against the device model.
// Inputs change 1 ns after each rising clock edge.
`timescale 1ns/100ps
module host_register_port_bench;
    typedef struct {logic w; logic [12:0] a; logic [7:0] d;} hrp_row_s;
    logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, device_reset_req = 1'b0;
    logic bus_protocol_select = 1'b0, irq_evt = 1'b0;
    hrp_pkg::hrp_req_s req = '0;
    logic req_ready, rsp_valid, irq_pending, chip_select_n, read_strobe_n, write_strobe_n;
    logic data_oe, device_reset_n, interrupt_out_n;
    logic [7:0] rsp_rdata, data_in, data_out, q;
    logic [12:0] addr;
    int error_cnt = 0, checks = 0, lo;
    hrp_row_s rows [7] = '{'{1, 13'h0000, 8'h01}, '{1, 13'h1fff, 8'h80}, '{1, 13'h0a55, 8'ha5},
        '{0, 13'h0000, 8'h01}, '{0, 13'h1fff, 8'h80}, '{0, 13'h0a55, 8'ha5}, '{0, 13'h0001, 8'h00}};
    always #5 clock = ~clock;
    hrp_host dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .device_reset_req(device_reset_req), .irq_pending(irq_pending),
        .bus_protocol_select(bus_protocol_select), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .device_reset_n(device_reset_n), .interrupt_out_n(interrupt_out_n));
    hrp_dev_model u_dev (.clock(clock), .bus_protocol_select(bus_protocol_select),
        .irq_evt(irq_evt), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .addr(addr), .data_out(data_out), .data_oe(data_oe),
        .device_reset_n(device_reset_n), .data_in(data_in), .interrupt_out_n(interrupt_out_n));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock) #1;
    endtask : cyc
    task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
        int n = 0;
        req = '{write: w, addr: a, wdata: d};
        req_valid = 1'b1;
        while (req_ready !== 1'b1) cyc(1);
        cyc(1);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(rsp_valid, 1'b1);
        q = rsp_rdata;
    endtask : acc
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end
    initial begin
        cyc(6);
        rst = 1'b0;
        chk({chip_select_n, read_strobe_n, write_strobe_n, data_oe, device_reset_n}, 5'h1d);
        foreach (rows[i]) begin
            acc(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(q, rows[i].d);
        end
        $display("Separate strobe accesses done");
        irq_evt = 1'b1;
        cyc(6);
        chk(irq_pending, 1'b1);
        irq_evt = 1'b0;
        cyc(6);
        chk(irq_pending, 1'b0);
        $display("Interrupt test done");
        bus_protocol_select = 1'b1;
        device_reset_req = 1'b1;
        cyc(1);
        device_reset_req = 1'b0;
        lo = 0;
        for (int n = 0; n < 300 && req_ready !== 1'b1; n++) begin
            if (device_reset_n === 1'b0) lo++;
            cyc(1);
        end
        chk(lo, 100);
        acc(1'b0, 13'h1fff, 8'h00);
        chk(q, 8'h00);
        irq_evt = 1'b1;
        cyc(6);
        chk(irq_pending, 1'b0);
        irq_evt = 1'b0;
        $display("Device reset test done");
        acc(1'b1, 13'h0123, 8'h3c);
        acc(1'b0, 13'h0123, 8'h00);
        chk(q, 8'h3c);
        $display("Data strobe mode test done");
        stop_test();
    end
endmodule : host_register_port_bench

// File: sim/hrp_dev_model.sv
// Behavioural model of the register device on the far side of the port.
// Data bus floats to a changing pattern when nobody drives it.
`timescale 1ns/100ps
module hrp_dev_model (
    clock,
    bus_protocol_select,
    irq_evt,
    chip_select_n,
    read_strobe_n,
    write_strobe_n,
    addr,
    data_out,
    data_oe,
    device_reset_n,
    data_in,
    interrupt_out_n
);
    input wire logic clock, bus_protocol_select, irq_evt, chip_select_n;
    input wire logic read_strobe_n, write_strobe_n, data_oe, device_reset_n;
    input wire logic [12:0] addr;
    input wire logic [7:0] data_out;
    output logic [7:0] data_in;
    output logic interrupt_out_n;
    logic [7:0] mem [0:8191];
    logic tog = 1'b0;
    logic drv;
    always @(posedge clock) tog <= ~tog;
    initial for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
    always @(negedge device_reset_n) for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
    // Reads act only under chip select, per bus mode
    assign drv = !chip_select_n && !read_strobe_n && (!bus_protocol_select || write_strobe_n);
    assign data_in = data_oe ? data_out : drv ? mem[addr] : 8'h5a ^ {8{tog}};
    always @(posedge write_strobe_n)
        if (!chip_select_n && !bus_protocol_select) mem[addr] = data_in;
    always @(posedge read_strobe_n)
        if (!chip_select_n && bus_protocol_select && !write_strobe_n) mem[addr] = data_in;
    // Address zero bit 0 is the global interrupt enable; open drain with pull-up
    assign interrupt_out_n = (irq_evt && mem[0][0]) ? 1'b0 : 1'b1;
endmodule : hrp_dev_model

// File: sim/hrp_host_sva.sv
// Pin-level checks for the host register port controller.
// Sees only the ports of hrp_host; attached by the bind at the foot.
`timescale 1ns/100ps
module hrp_host_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic irq_pending,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [12:0] addr,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic device_reset_n,
    input wire logic interrupt_out_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_rd_needs_cs: assert property (!read_strobe_n |-> !chip_select_n)
        else $error("read strobe without chip select");
    a_wr_needs_cs: assert property (!write_strobe_n |-> !chip_select_n)
        else $error("write strobe without chip select");
    a_no_bus_fight: assert property (!read_strobe_n && write_strobe_n |-> !data_oe)
        else $error("host drives data during a read");
    a_wr_data_held: assert property ($rose(write_strobe_n) && !chip_select_n
        |-> data_oe && $stable(data_out))
        else $error("write data not held at strobe rise");
    a_strobe_width: assert property ($fell(read_strobe_n) |-> !read_strobe_n[*6])
        else $error("strobe low phase too short");
    a_addr_steady: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(addr))
        else $error("address moved within an access");
    a_access_ends: assert property (req_valid && req_ready
        |-> ##[1:2] !chip_select_n ##[8:11] (rsp_valid && chip_select_n))
        else $error("access timing wrong");
    a_irq_seen: assert property ($fell(interrupt_out_n) |-> ##[1:4] irq_pending)
        else $error("interrupt not reported");
    a_reset_pulse: assert property ($fell(device_reset_n) |-> !device_reset_n[*8])
        else $error("device reset pulse too short");
    a_reset_busy: assert property (!device_reset_n |-> !req_ready)
        else $error("request accepted during device reset");
    c_write: cover property ($rose(write_strobe_n) && !chip_select_n);
    c_read: cover property ($rose(read_strobe_n) && write_strobe_n);
    c_reset: cover property ($rose(device_reset_n));
endmodule : hrp_host_sva
bind hrp_host hrp_host_sva u_sva (.*);
